// file: hdl/tlm_pkg.sv
// Shared constants, state codes and step functions for the telemetry encoder and PN sync.
// Assumes a single sys_clk domain; all counts are in sys_clk cycles or in chips and bits.

package tlm_pkg;

	// ==========================================================
	// Codeword layout
	localparam int CHECK_BITS = 28;
	localparam logic [6:0] LAST_DATA_IDX = 7'h2c;
	localparam logic [6:0] LAST_BIT_IDX = 7'h48;
	localparam logic [6:0] FIRST_BIT_IDX = 7'h00;

	// ==========================================================
	// Chips per bit, stored as last chip index
	localparam logic [4:0] CHIP_LAST_DEEP = 5'h06;
	localparam logic [4:0] CHIP_LAST_TLM = 5'h02;
	localparam logic [4:0] CHIP_LAST_CMD = 5'h1e;

	// ==========================================================
	// Sequence lengths as state masks; the seed is the mask itself
	localparam logic [8:0] PN_MASK_DEEP = 9'h1ff;
	localparam logic [8:0] PN_MASK_CMD = 9'h01f;
	localparam logic [8:0] PN_MASK_TLM = 9'h003;

	// ==========================================================
	// Default code polynomial and feedback taps
	localparam logic [27:0] GEN_POLY_DEFAULT = 28'h0a0_0001;
	localparam logic [8:0] PN_DEEP_TAPS_DEFAULT = 9'h110;
	localparam logic [8:0] PN_CMD_TAPS_DEFAULT = 9'h014;
	localparam logic [8:0] PN_TLM_TAPS_DEFAULT = 9'h003;

	// ==========================================================
	// Timing and buffering
	localparam logic [7:0] HALF_CHIP_CYCLES_DEFAULT = 8'h04;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 1;

	// ==========================================================
	// Reset values
	localparam logic [27:0] PAR_RESET = 28'h000_0000;
	localparam logic [4:0] CHIP_RESET = 5'h00;
	localparam logic [7:0] HALF_RESET = 8'h00;

	// ==========================================================
	// Encoder phase
	typedef enum logic [2:0]
	{
		ST_DATA = 3'b001,
		ST_CHECK = 3'b010,
		ST_RELAY = 3'b100
	} enc_state_t;

	// ==========================================================
	// Systematic cyclic check register step
	function automatic logic [27:0] parity_step(input logic [27:0] p, input logic d,
		input logic [27:0] g);
		logic fb;
		fb = d ^ p[27];
		return {p[26:0], 1'b0} ^ (fb ? g : PAR_RESET);
	endfunction

	// PN step, the mask selects the sequence length
	function automatic logic [8:0] pn_step(input logic [8:0] s, input logic [8:0] taps,
		input logic [8:0] mask);
		logic fb;
		fb = ^(s & taps);
		return {s[7:0], fb} & mask;
	endfunction

endpackage

// file: hdl/stream_fifo.sv
// Synchronous FIFO with a registered output stage and valid/ready on both sides.
// Assumes DEPTH is a power of two so the pointers wrap by themselves.
`timescale 1ns/10ps

module stream_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] cnt_reg;
	logic [AW:0] cnt_next;
	logic ready_reg;
	logic out_valid_reg;
	logic [WIDTH-1:0] out_data_reg;

	// ==========================================================
	// Handshake decode
	wire push = in_valid & ready_reg;
	wire load = (cnt_reg != '0) & (~out_valid_reg | out_ready);

	assign cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
	assign in_ready = ready_reg;
	assign out_valid = out_valid_reg;
	assign out_data = out_data_reg;

	// ==========================================================
	// Storage has no reset; only pointers and flags need one
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg <= '0;
			ready_reg <= 1'b1;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(load);
			cnt_reg <= cnt_next;
			ready_reg <= (cnt_next != FULL_COUNT);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_valid_reg <= 1'b0;
			out_data_reg <= '0;
		end
		else if (load)
		begin
			out_valid_reg <= 1'b1;
			out_data_reg <= mem_reg[rd_ptr_reg];
		end
		else if (out_ready)
			out_valid_reg <= 1'b0;
	end

endmodule

// file: hdl/telemetry_block_encoder_pn_sync.sv
// Telemetry channel coder: cyclic block encoder followed by a PN bit sync generator.
// Assumes the storage source clocks bits in through the FIFO and the modulator samples tx_symbol.
`timescale 1ns/10ps

// Contract
// RQ1: The source delivers 45 data bits as one burst at the bit rate and then nothing for 28 bits.
// RQ2: The encoder computes 28 check bits over each 45-bit burst in a cyclic register and appends them.
// RQ3: Each codeword leaves as one unbroken serial run of 73 bits, data first then check bits.
// RQ4: Deep-space mode combines a 511-chip PN sequence on a square subcarrier with the 73 bits.
// RQ5: Deep-space mode advances exactly seven PN chips in every data bit period.
// RQ6: The composite output is one two-level signal able to drive a binary phase modulator.
// RQ7: The receiver produces a marker at each bit start and at each 73-bit group start once locked.
// No receiver here; bit_start and word_start give these markers on the transmit side.
// RQ8: The receiver resets its decoder with the group marker at every codeword boundary; no receiver here, word_start marks codeword starts.
// RQ9: Relay mode uses a short PN sequence of three chips for telemetry and 31 for commands.
// RQ10: In relay mode the short sequence restarts every data bit and no check bits are inserted.
// RQ11: On the relay path the encoder is bypassed and raw bits go straight to the sync generator.
// RQ12: In deep-space mode the 511-chip sequence restarts on the first bit of each codeword.
// RQ13: The code polynomial and the PN feedback taps are design parameters.

module telemetry_block_encoder_pn_sync
	import tlm_pkg::*;
#(
	parameter logic [27:0] GEN_POLY = GEN_POLY_DEFAULT,
	parameter logic [8:0] PN_DEEP_TAPS = PN_DEEP_TAPS_DEFAULT,
	parameter logic [8:0] PN_CMD_TAPS = PN_CMD_TAPS_DEFAULT,
	parameter logic [8:0] PN_TLM_TAPS = PN_TLM_TAPS_DEFAULT,
	parameter logic [7:0] HALF_CHIP_CYCLES = HALF_CHIP_CYCLES_DEFAULT
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Mode selection, sampled at bit or codeword boundaries
	input wire logic relay_sel,
	input wire logic relay_cmd_link,
	// Serial data from storage
	input wire logic src_valid,
	input wire logic src_bit,
	output logic src_ready,
	// Composite to the phase modulator
	output logic tx_symbol,
	// Transmit-side timing markers, mode and underrun flags
	output logic bit_start,
	output logic word_start,
	output logic relay_active,
	output logic underrun
);

	// ==========================================================
	// Declarations
	enc_state_t state_reg;
	enc_state_t state_next;
	logic cmd_reg;
	logic [7:0] half_cnt_reg;
	logic sub_reg;
	logic [4:0] chip_cnt_reg;
	logic [6:0] bit_idx_reg;
	logic [27:0] par_reg;
	logic [27:0] par_next;
	logic [8:0] pn_reg;
	logic cur_bit_reg;
	logic cur_bit_next;
	logic tx_reg;
	logic bit_end_dly_reg;
	logic word_end_dly_reg;
	logic bit_start_reg;
	logic word_start_reg;
	logic underrun_reg;
	logic fifo_valid;
	logic fifo_bit;
	logic fifo_take;
	logic relay_active_reg;

	// ==========================================================
	// Input buffer; src_ready falls when it is full, which stalls the storage clock-out
	stream_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.in_valid(src_valid),
		.in_data(src_bit),
		.in_ready(src_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_bit),
		.out_ready(fifo_take)
	);

	// ==========================================================
	// Chip and subcarrier timing
	wire half_tick = (half_cnt_reg == HALF_CHIP_CYCLES - 8'h01);
	// One subcarrier cycle per chip; the chip ends on the second half
	wire chip_tick = half_tick & sub_reg;
	wire in_relay = (state_reg == ST_RELAY);

	// Chips per bit follow the mode in force for the current bit
	wire [4:0] chip_last = in_relay ? (cmd_reg ? CHIP_LAST_CMD : CHIP_LAST_TLM)
		: CHIP_LAST_DEEP; // [RQ5] [RQ9]
	wire bit_end = chip_tick & (chip_cnt_reg == chip_last);
	wire word_end = ~in_relay & (bit_idx_reg == LAST_BIT_IDX);

	// ==========================================================
	// Mode changes only at a codeword end, or at any bit end in relay mode,
	// so a codeword is never cut short
	wire mode_ok = in_relay | word_end;
	wire relay_next = mode_ok ? relay_sel : in_relay;
	wire cmd_next = mode_ok ? relay_cmd_link : cmd_reg;

	// ==========================================================
	// Bit position and phase of the next bit
	// Leaving relay mode opens a fresh codeword at bit 0
	wire [6:0] idx_next = (relay_next | in_relay | word_end) ? FIRST_BIT_IDX
		: bit_idx_reg + 7'h01; // [RQ3] [RQ12]
	wire word_first = ~relay_next & (idx_next == FIRST_BIT_IDX);

	always_comb
	begin
		if (relay_next)
			state_next = ST_RELAY; // [RQ11]
		else if (idx_next <= LAST_DATA_IDX)
			state_next = ST_DATA;
		else
			state_next = ST_CHECK; // [RQ2]
	end

	// A data slot draws one bit; a missing bit is sent as zero and flagged
	wire want_data = (state_next != ST_CHECK);
	assign fifo_take = bit_end & want_data & fifo_valid; // [RQ1]
	wire data_bit = fifo_valid & fifo_bit;
	wire starve = bit_end & want_data & ~fifo_valid;

	// ==========================================================
	// Cyclic check register: cleared at each codeword start, fed with data bits,
	// then shifted out behind them
	wire [27:0] par_base = word_first ? PAR_RESET : par_reg;

	always_comb
	begin
		unique case (state_next)
			ST_DATA:
			begin
				par_next = parity_step(par_base, data_bit, GEN_POLY); // [RQ2] [RQ13]
				cur_bit_next = data_bit; // [RQ3]
			end
			ST_CHECK:
			begin
				par_next = {par_reg[26:0], 1'b0};
				cur_bit_next = par_reg[CHECK_BITS-1]; // [RQ2] [RQ3]
			end
			ST_RELAY:
			begin
				// Raw bits only; the check register stays idle
				par_next = PAR_RESET;
				cur_bit_next = data_bit; // [RQ10] [RQ11]
			end
		endcase
	end

	// ==========================================================
	// PN sequence selection; the seed of each sequence is its own mask
	function automatic logic [8:0] pn_mask_of(input logic relay, input logic cmd);
		if (!relay)
			return PN_MASK_DEEP;
		else if (cmd)
			return PN_MASK_CMD;
		else
			return PN_MASK_TLM;
	endfunction

	wire [8:0] pn_mask_cur = pn_mask_of(in_relay, cmd_reg); // [RQ9]
	wire [8:0] pn_taps_cur = in_relay ? (cmd_reg ? PN_CMD_TAPS : PN_TLM_TAPS) : PN_DEEP_TAPS;
	wire [8:0] pn_seed_next = pn_mask_of(relay_next, cmd_next); // [RQ9]
	wire [8:0] pn_adv = pn_step(pn_reg, pn_taps_cur, pn_mask_cur); // [RQ13]
	// Restart per bit in relay mode, per codeword in deep-space mode
	wire pn_restart = relay_next | word_first; // [RQ10] [RQ12]

	// ==========================================================
	// Composite: data, chip and subcarrier folded into one binary level
	wire tx_next = cur_bit_reg ^ pn_reg[0] ^ sub_reg; // [RQ4] [RQ6]

	// ==========================================================
	// Timing counters
	// Half-chip divider
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			half_cnt_reg <= HALF_RESET;
		else if (half_tick)
			half_cnt_reg <= HALF_RESET;
		else
			half_cnt_reg <= half_cnt_reg + 8'h01;
	end

	// Subcarrier phase: low in the first half of each chip, high in the second
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			sub_reg <= 1'b0;
		else if (half_tick)
			sub_reg <= ~sub_reg; // [RQ4]
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			chip_cnt_reg <= CHIP_RESET;
		else if (bit_end)
			chip_cnt_reg <= CHIP_RESET;
		else if (chip_tick)
			chip_cnt_reg <= chip_cnt_reg + 5'h01; // [RQ5]
	end

	// ==========================================================
	// Bit sequencer; reset parks on the last check bit so the first
	// bit end opens a fresh codeword
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_CHECK;
			cmd_reg <= 1'b0;
			relay_active_reg <= 1'b0;
		end
		else if (bit_end)
		begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			// relay_active follows the mode of the bit now loaded
			relay_active_reg <= relay_next; // [RQ11]
		end
	end

	// Bit position and data path
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_idx_reg <= LAST_BIT_IDX;
			par_reg <= PAR_RESET;
			cur_bit_reg <= 1'b0;
		end
		else if (bit_end)
		begin
			bit_idx_reg <= idx_next;
			par_reg <= par_next;
			cur_bit_reg <= cur_bit_next;
		end
	end

	// ==========================================================
	// PN register
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			pn_reg <= PN_MASK_DEEP;
		else if (bit_end & pn_restart)
			pn_reg <= pn_seed_next; // [RQ10] [RQ12]
		else if (chip_tick)
			pn_reg <= pn_adv; // [RQ4] [RQ5]
	end

	// ==========================================================
	// Output stage; the symbol register runs every cycle to follow the subcarrier
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_reg <= 1'b0;
		else
			tx_reg <= tx_next; // [RQ6]
	end

	// Markers take two stages, matching the cur_bit_reg and tx_reg path
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_end_dly_reg <= 1'b0;
			word_end_dly_reg <= 1'b0;
			bit_start_reg <= 1'b0;
			word_start_reg <= 1'b0;
			underrun_reg <= 1'b0;
		end
		else
		begin
			bit_end_dly_reg <= bit_end;
			word_end_dly_reg <= bit_end & word_first;
			bit_start_reg <= bit_end_dly_reg;
			word_start_reg <= word_end_dly_reg;
			underrun_reg <= starve;
		end
	end

	// Every output leaves a flip-flop
	assign tx_symbol = tx_reg;
	assign bit_start = bit_start_reg;
	assign word_start = word_start_reg;
	assign relay_active = relay_active_reg;
	assign underrun = underrun_reg;

endmodule

// file: bench/tx_chk.sv
// Checker for the telemetry coder: bit and codeword timing, markers, FIFO refusal.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps

module tx_chk
	import tlm_pkg::*;
#(
	parameter logic [7:0] HALF_CHIP_CYCLES = HALF_CHIP_CYCLES_DEFAULT
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Watched ports
	input wire logic relay_sel,
	input wire logic relay_cmd_link,
	input wire logic src_valid,
	input wire logic src_bit,
	input wire logic src_ready,
	input wire logic tx_symbol,
	input wire logic bit_start,
	input wire logic word_start,
	input wire logic relay_active,
	input wire logic underrun
);
	localparam int HALF = int'(HALF_CHIP_CYCLES);
	// ==========================================================
	// Counters since the last markers; 16 bits hold a codeword at the default rate
	logic [15:0] gap_reg;
	logic [15:0] wgap_reg;
	logic seen_reg;
	logic wseen_reg;
	logic mode_reg;
	logic tx0_reg;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gap_reg <= 16'h0000;
			wgap_reg <= 16'h0000;
			seen_reg <= 1'b0;
			wseen_reg <= 1'b0;
			mode_reg <= 1'b0;
			tx0_reg <= 1'b0;
		end
		else
		begin
			gap_reg <= bit_start ? 16'h0001 : gap_reg + 16'h0001;
			wgap_reg <= word_start ? 16'h0001 : wgap_reg + 16'h0001;
			seen_reg <= seen_reg | bit_start;
			wseen_reg <= word_start | (wseen_reg & ~(bit_start & relay_active));
			mode_reg <= bit_start ? relay_active : mode_reg;
			tx0_reg <= bit_start ? tx_symbol : tx0_reg;
		end
	end

	// ==========================================================
	// Assertions
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	word_bit_a: assert property (word_start |-> bit_start)
		else $error("word marker without bit marker");
	relay_word_a: assert property (bit_start && relay_active |-> !word_start)
		else $error("word marker in relay mode");
	sub_flip_a: assert property (seen_reg && gap_reg == HALF |-> tx_symbol != tx0_reg)
		else $error("subcarrier did not invert at mid chip");
	bit_pulse_a: assert property (bit_start |=> !bit_start)
		else $error("bit marker longer than one cycle");
	deep_gap_a: assert property (bit_start && seen_reg && !mode_reg |-> gap_reg == 14 * HALF)
		else $error("deep bit is not seven chips");
	relay_gap_a: assert property (bit_start && seen_reg && mode_reg
		|-> gap_reg == 6 * HALF || gap_reg == 62 * HALF)
		else $error("relay bit length wrong");
	word_due_a: assert property (wseen_reg && wgap_reg == 1022 * HALF |-> word_start || relay_active)
		else $error("codeword not 73 bits long");
	ready_fill_a: assert property ($fell(src_ready) |-> $past(src_valid))
		else $error("ready dropped without a push");

	cover property (word_start);
	cover property (bit_start && relay_active);
	cover property (underrun);
	cover property (!src_ready);
endmodule

bind telemetry_block_encoder_pn_sync tx_chk #(.HALF_CHIP_CYCLES(HALF_CHIP_CYCLES)) chk (
	.sys_clk(sys_clk), .rst_n(rst_n), .relay_sel(relay_sel), .relay_cmd_link(relay_cmd_link),
	.src_valid(src_valid), .src_bit(src_bit), .src_ready(src_ready), .tx_symbol(tx_symbol),
	.bit_start(bit_start), .word_start(word_start), .relay_active(relay_active),
	.underrun(underrun));

// file: bench/storage_source.sv
// Model of the clocked storage: sends a burst LSB first, holding each bit until taken.
// Assumes the bench pulses go for one cycle while the model is idle.
`timescale 1ns/10ps

module storage_source (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Burst request
	input wire logic go,
	input wire logic [63:0] burst,
	input wire logic [6:0] len,
	// Serial link
	output logic src_valid,
	output logic src_bit,
	input wire logic src_ready
);
	logic [63:0] sh_reg;
	logic [6:0] left_reg;
	logic last_reg;

	// One contiguous burst, then silence
	assign src_valid = (left_reg != 7'h00);
	// Idle line shows no stale bit
	assign src_bit = src_valid ? sh_reg[0] : ~last_reg;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sh_reg <= 64'h0;
			left_reg <= 7'h00;
			last_reg <= 1'b0;
		end
		else if (go)
		begin
			sh_reg <= burst;
			left_reg <= len;
		end
		else if (src_valid && src_ready)
		begin
			sh_reg <= sh_reg >> 1;
			left_reg <= left_reg - 7'h01;
			last_reg <= sh_reg[0];
		end
	end
endmodule

// file: bench/telemetry_block_encoder_pn_sync_tb.sv
// Bench: one deep codeword, relay telemetry bits, starved command bits, then back to deep.
// Assumes HALF_CHIP_CYCLES of 1, so a deep bit lasts 14 cycles.
`timescale 1ns/10ps

module telemetry_block_encoder_pn_sync_tb;
	logic sys_clk, rst_n, relay_sel, relay_cmd_link, go, src_valid, src_bit, src_ready;
	logic tx_symbol, bit_start, word_start, relay_active, underrun;
	logic und_seen = 1'b0;
	logic [63:0] burst;
	logic [6:0] len;
	int error_cnt = 0;
	int n_checks = 0;

	telemetry_block_encoder_pn_sync #(.HALF_CHIP_CYCLES(8'h01)) dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .relay_sel(relay_sel), .relay_cmd_link(relay_cmd_link),
		.src_valid(src_valid), .src_bit(src_bit), .src_ready(src_ready), .tx_symbol(tx_symbol),
		.bit_start(bit_start), .word_start(word_start), .relay_active(relay_active),
		.underrun(underrun));
	storage_source src (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .burst(burst), .len(len),
		.src_valid(src_valid), .src_bit(src_bit), .src_ready(src_ready));

	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
		if (underrun === 1'b1)
			und_seen <= 1'b1;

	// ==========================================================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Called at a rising edge; returns one edge later
	task automatic push(input logic [63:0] b, input logic [6:0] n);
		go <= 1'b1;
		burst <= b;
		len <= n;
		@(posedge sys_clk);
		go <= 1'b0;
	endtask

	// Sampled 1 ns after the edge so the marker has settled
	task automatic wait_bit(output int n);
		n = 0;
		do
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (bit_start !== 1'b1 && n < 300);
		if (n >= 300)
			error_cnt++;
	endtask

	// ==========================================================
	// Scenarios
	task automatic deep_word();
		logic [44:0] d;
		logic [27:0] p;
		logic [8:0] s;
		logic e;
		int k;
		int j;
		int n;
		d = 45'h0a5c_3f19_e2d7;
		p = 28'h000_0000;
		for (k = 0; k < 45; k++)
		begin
			e = d[k] ^ p[27];
			p = {p[26:0], 1'b0} ^ (e ? tlm_pkg::GEN_POLY_DEFAULT : 28'h000_0000);
		end
		push(64'(d), 7'h2d);
		n = 0;
		while (word_start !== 1'b1 && n < 80)
		begin
			wait_bit(j);
			n++;
		end
		s = 9'h1ff;
		for (k = 0; k < 73; k++)
		begin
			if (k > 0)
				wait_bit(n);
			if (k < 45)
				check("data_bit", tx_symbol, d[k] ^ s[0]);
			else
				check("check_bit", tx_symbol, p[72 - k] ^ s[0]);
			for (j = 0; j < 7; j++)
				s = {s[7:0], ^(s & tlm_pkg::PN_DEEP_TAPS_DEFAULT)};
			if (k == 50)
			begin
				// Relay bits queue during check slots, overfilling the FIFO by one
				@(posedge sys_clk);
				relay_sel <= 1'b1;
				push(64'h0000_0000_0002_d3b6, 7'h12);
			end
			if (k == 52)
				check("fifo_full", src_ready, 0);
		end
	endtask

	task automatic relay_run();
		logic [17:0] r;
		int k;
		int n;
		r = 18'h2_d3b6;
		for (k = 0; k < 18; k++)
		begin
			wait_bit(n);
			check("relay_bit", tx_symbol, r[k] ^ 1'b1);
			check("relay_mode", relay_active, 1);
			if (k > 0)
				check("tlm_bit_len", n, 6);
		end
		@(posedge sys_clk);
		relay_cmd_link <= 1'b1;
		n = 0;
		for (k = 0; k < 6 && n != 62; k++)
			wait_bit(n);
		wait_bit(n);
		check("cmd_bit_len", n, 62);
		check("cmd_fill", tx_symbol, 1);
		check("underrun_seen", und_seen, 1);
		// Back to deep mode: the next bit must open a codeword
		@(posedge sys_clk);
		relay_sel <= 1'b0;
		wait_bit(n);
		check("deep_restart", word_start, 1);
		check("deep_mode", relay_active, 0);
		check("deep_fill", tx_symbol, 1);
	endtask

	initial
	begin
		rst_n = 1'b0;
		relay_sel = 1'b0;
		relay_cmd_link = 1'b0;
		go = 1'b0;
		burst = 64'h0;
		len = 7'h00;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		deep_word();
		relay_run();
		report_and_stop();
	end

	// About 1,350 cycles are needed; the limit leaves wide margin
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		report_and_stop();
	end
endmodule
